// *** oss_top.sv ***
/*
 * system oscillator select: source choice from option bits, pin release,
 * sleep gating, watchdog and time base clock supply, slow crystal power
 * mode and the axi4-lite register slave.
 * assumes oscillator levels arrive unsynchronised, sleep_req comes from
 * the cpu on clk, and the bus master follows axi4-lite.
 */
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
//Operation
//- five sources, three fast, two slow
//- external crystal uses both oscillator pins
//- external rc uses first pin, frees bit5
//- fast rc fixed at 4, 8 or 12 MHz
//- fast rc frees port a bits 5, 6
//- sleep stops system clock, slow crystal runs
//- slow crystal independent, on both pins
//- slow crystal only paired with fast rc
//- also clocks watchdog and time base
//- low-power bit: 0 quick, 1 low power
//- low-power bit cleared at power-on
//- low power never stops slow crystal
//- slow select bit picks crystal, stops rc
//- slow crystal works in either mode
`timescale 1ns/1ps
module oss_top #(
	parameter int ADDR_W = 8 // register address width
) (
	// clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// configuration option bits
	input  wire logic [1:0]        cfg_osc_type,
	input  wire logic [1:0]        cfg_fast_rc_freq,
	input  wire logic              cfg_slow_rc_en,
	// raw oscillator levels
	input  wire logic              osc_pin_in,
	input  wire logic              int_fast_rc_osc,
	input  wire logic              int_slow_rc_osc,
	// cpu power state
	input  wire logic              sleep_req,
	// oscillator and pin control
	output logic                   osc_amp_en,
	output logic                   fast_rc_en,
	output logic [1:0]             fast_rc_freq_sel,
	output logic                   slow_osc_en,
	output logic                   slow_osc_low_power,
	output logic                   slow_rc_en,
	output logic                   port_a_bit5_gpio,
	output logic                   port_a_bit6_gpio,
	// clock ticks
	output logic                   sys_tick,
	output logic                   wdt_tick,
	output logic                   timebase_tick,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
`include "oss_consts.svh"

	// word offset decode shared by the read and write paths
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction

	// latched configuration
	logic                cfg_loaded;   // options captured after reset
	oss_pkg::oss_osc_t   osc_type;     // oscillator option
	oss_pkg::oss_freq_t  fast_freq;    // fast rc frequency option
	logic                slow_rc_on;   // slow rc option

	// software control bits
	logic [1:0]          ctrl;         // slow select and low power

	// synchronised ticks
	wire                 pin_rise;     // osc pin rising edge
	wire                 frc_rise;     // fast rc rising edge
	wire                 src_rise;     // slow rc rising edge

	// decoded configuration
	wire                 paired;       // fast rc with slow crystal
	wire                 uses_frc;     // fast rc is the fast source
	wire                 fast_src;     // tick of the fast source
	wire                 slow_xtal;    // tick of the slow crystal
	wire                 next_sys;     // gated system tick
	wire                 next_wdt;     // watchdog tick
	wire                 next_tb;      // time base tick
	oss_pkg::oss_freq_t  freq_legal;   // frequency with reserved mapped

	// bus state
	logic                aw_got;       // write address held
	logic                w_got;        // write data held
	logic [ADDR_W-1:0]   aw_addr;      // held write address
	logic [31:0]         w_data;       // held write data
	logic [3:0]          w_strb;       // held byte enables
	wire                 do_write;     // both halves present
	wire                 wr_ctrl;      // write hits control
	wire [31:0]          status_word;  // status read value
	wire [31:0]          next_rdata;   // read mux result
	wire                 rd_hit;       // read address mapped

	// glitch-free switch link
	oss_sw_if            sw_link ();

	// synchronisers for each oscillator level
	oss_sync3 u_sync_pin (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.raw  (osc_pin_in),
		.rise (pin_rise)
	);
	oss_sync3 u_sync_frc (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.raw  (int_fast_rc_osc),
		.rise (frc_rise)
	);
	oss_sync3 u_sync_src (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.raw  (int_slow_rc_osc),
		.rise (src_rise)
	);

	// fast/slow hand-over
	oss_clk_switch u_switch (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.sw  (sw_link)
	);

	// option bits caught once, on the first enabled cycle after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_loaded <= 1'b0;
			osc_type   <= oss_pkg::OSS_OSC_FAST_RC;
			fast_freq  <= oss_pkg::OSS_FREQ_4M;
			slow_rc_on <= 1'b0;
		end else if (ce && !cfg_loaded) begin
			cfg_loaded <= 1'b1;
			osc_type   <= oss_pkg::oss_osc_t'(cfg_osc_type);
			fast_freq  <= oss_pkg::oss_freq_t'(cfg_fast_rc_freq);
			slow_rc_on <= cfg_slow_rc_en;
		end
	end

	// source decode
	assign paired     = (osc_type == oss_pkg::OSS_OSC_PAIRED);
	assign uses_frc   = (osc_type == oss_pkg::OSS_OSC_FAST_RC) || paired;
	// external crystal and rc both arrive on the first pin
	assign fast_src   = uses_frc ? frc_rise : pin_rise;
	// slow crystal shares the pins, only when paired
	assign slow_xtal  = paired && pin_rise;
	// reserved frequency code falls back to the lowest rate
	assign freq_legal = (fast_freq == oss_pkg::OSS_FREQ_12M || fast_freq == oss_pkg::OSS_FREQ_8M) ?
	                    fast_freq : oss_pkg::OSS_FREQ_4M;

	// switch requests; slow select only counts when paired
	assign sw_link.fast_tick = fast_src;
	assign sw_link.slow_tick = slow_xtal;
	assign sw_link.want_slow = paired && ctrl[`OSS_CTRL_SLOWSEL];

	// tick routing
	assign next_sys = sw_link.tick && !sleep_req && cfg_loaded;
	// watchdog prefers the slow rc, then the slow crystal, then sysclk
	assign next_wdt = slow_rc_on ? src_rise : (paired ? slow_xtal : next_sys);
	// time base keeps counting on the slow crystal in sleep
	assign next_tb  = paired ? slow_xtal : next_sys;

	// registered oscillator controls and pin release
	always_ff @(posedge clk) begin
		if (rst) begin
			osc_amp_en       <= 1'b0;
			fast_rc_en       <= 1'b0;
			fast_rc_freq_sel <= oss_pkg::OSS_FREQ_4M;
			slow_osc_en      <= 1'b0;
			slow_rc_en       <= 1'b0;
			port_a_bit5_gpio <= 1'b0;
			port_a_bit6_gpio <= 1'b0;
		end else if (ce) begin
			// amplifier runs for external crystal outside sleep, or for slow crystal always
			osc_amp_en <= cfg_loaded && ((osc_type == oss_pkg::OSS_OSC_EXT_XTAL && !sleep_req) ||
			                             paired);
			// fast rc stops in sleep and in slow mode
			fast_rc_en <= cfg_loaded && uses_frc && sw_link.fast_en && !sleep_req;
			fast_rc_freq_sel <= freq_legal;
			// slow crystal never stopped by sleep or low power
			slow_osc_en <= cfg_loaded && paired;
			slow_rc_en  <= cfg_loaded && slow_rc_on;
			// bit5 free for rc and internal rc, bit6 free for internal rc only
			port_a_bit5_gpio <= cfg_loaded && (osc_type == oss_pkg::OSS_OSC_EXT_RC ||
			                                   osc_type == oss_pkg::OSS_OSC_FAST_RC);
			port_a_bit6_gpio <= cfg_loaded && (osc_type == oss_pkg::OSS_OSC_FAST_RC);
		end
	end

	// registered ticks and low power select
	always_ff @(posedge clk) begin
		if (rst) begin
			sys_tick           <= 1'b0;
			wdt_tick           <= 1'b0;
			timebase_tick      <= 1'b0;
			slow_osc_low_power <= 1'b0;
		end else if (ce) begin
			sys_tick      <= next_sys;
			wdt_tick      <= next_wdt;
			timebase_tick <= next_tb;
			// only start-up time changes with this bit
			slow_osc_low_power <= paired && ctrl[`OSS_CTRL_LOWPWR];
		end
	end

	// write path decode
	assign do_write = aw_got && w_got && !s_axi_bvalid;
	assign wr_ctrl  = addr_is(aw_addr, `OSS_OFF_CTRL);

	// control register, cleared at power-on
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= `OSS_CTRL_RST;
		end else if (ce && do_write && wr_ctrl && w_strb[0]) begin
			ctrl <= w_data[1:0];
		end
	end

	// write address and data taken in either order, answered together
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `OSS_RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= '0;
			w_data        <= `OSS_DATA_ZERO;
			w_strb        <= 4'h0;
		end else if (ce) begin
			// ready rises after reset and after each response
			if (!aw_got && !s_axi_awready && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end else if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_got        <= 1'b1;
				aw_addr       <= s_axi_awaddr;
			end
			if (!w_got && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end else if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_got        <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
			end
			// response once both halves are held
			if (do_write) begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ctrl ? `OSS_RESP_OKAY : `OSS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// status word shows switch, option and sleep state
	assign status_word = {24'h00_0000, sleep_req, slow_rc_on, freq_legal, osc_type,
	                      sw_link.busy, sw_link.slow_active};
	assign rd_hit      = addr_is(s_axi_araddr, `OSS_OFF_CTRL) || addr_is(s_axi_araddr, `OSS_OFF_STATUS);
	assign next_rdata  = addr_is(s_axi_araddr, `OSS_OFF_CTRL)   ? {30'h0000_0000, ctrl} :
	                     addr_is(s_axi_araddr, `OSS_OFF_STATUS) ? status_word : `OSS_DATA_ZERO;

	// read: one address at a time, data one cycle after the handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `OSS_DATA_ZERO;
			s_axi_rresp   <= `OSS_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= next_rdata;
				s_axi_rresp   <= rd_hit ? `OSS_RESP_OKAY : `OSS_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// option bits never move once loaded
	chk_cfg_frozen: assert property (@(posedge clk) disable iff (rst)
		cfg_loaded ##1 cfg_loaded |-> $stable(osc_type) && $stable(fast_freq))
		else $error("oscillator option changed at run time");
	// external rc frees bit5 only
	chk_erc_pins: assert property (@(posedge clk) disable iff (rst)
		ce && cfg_loaded && osc_type == oss_pkg::OSS_OSC_EXT_RC |=> port_a_bit5_gpio && !port_a_bit6_gpio)
		else $error("external rc pin release wrong");
	// internal rc frees both pins
	chk_frc_pins: assert property (@(posedge clk) disable iff (rst)
		ce && cfg_loaded && osc_type == oss_pkg::OSS_OSC_FAST_RC |=> port_a_bit5_gpio && port_a_bit6_gpio)
		else $error("internal rc pin release wrong");
	// no system tick during sleep
	chk_sleep_stop: assert property (@(posedge clk) disable iff (rst)
		ce && sleep_req |=> !sys_tick && !fast_rc_en)
		else $error("system clock ran in sleep");
	// slow crystal keeps running whatever the power bit
	chk_slow_runs: assert property (@(posedge clk) disable iff (rst)
		ce && cfg_loaded && paired |=> slow_osc_en)
		else $error("slow crystal stopped");
	// power bit clear right after reset
	chk_lp_reset: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> !slow_osc_low_power && ctrl == `OSS_CTRL_RST)
		else $error("low power bit not cleared at reset");
	// power bit reaches the crystal in paired mode
	chk_lp_map: assert property (@(posedge clk) disable iff (rst)
		ce && paired |=> slow_osc_low_power == $past(ctrl[`OSS_CTRL_LOWPWR]))
		else $error("low power mode not applied");
	// slow system clock impossible outside paired mode
	chk_slow_paired: assert property (@(posedge clk) disable iff (rst)
		cfg_loaded && !paired |-> !sw_link.slow_active)
		else $error("slow clock used without pairing");
	// time base follows slow crystal in paired mode
	chk_tb_source: assert property (@(posedge clk) disable iff (rst)
		ce && paired |=> timebase_tick == $past(slow_xtal))
		else $error("time base source wrong");
endmodule

// *** oss_consts.svh ***
/*
 * constants for the system oscillator select block: register offsets,
 * field positions and reset values.
 * assumes it is included by its bare name inside module bodies.
 */
`ifndef OSS_CONSTS_SVH
`define OSS_CONSTS_SVH

// register byte offsets, one aligned word each
`define OSS_OFF_CTRL        8'h00
`define OSS_OFF_STATUS      8'h04
// control register fields
`define OSS_CTRL_SLOWSEL    0
`define OSS_CTRL_LOWPWR     1
// status register fields
`define OSS_ST_SLOWACT      0
`define OSS_ST_BUSY         1
`define OSS_ST_TYPE_LO      2
`define OSS_ST_FREQ_LO      4
`define OSS_ST_SLOWRC       6
`define OSS_ST_SLEEP        7
// reset values and bus answers
`define OSS_CTRL_RST        2'h0
`define OSS_RESP_OKAY       2'h0
`define OSS_RESP_SLVERR     2'h2
`define OSS_DATA_ZERO       32'h0000_0000

`endif

// *** oss_pkg.sv ***
/*
 * types shared by the oscillator select modules.
 * assumes nothing beyond a systemverilog compiler.
 */
package oss_pkg;
	// oscillator configuration option
	typedef enum logic [1:0] {
		OSS_OSC_EXT_XTAL  = 2'h0, // external crystal across both pins
		OSS_OSC_EXT_RC    = 2'h1, // external rc on first pin
		OSS_OSC_FAST_RC   = 2'h2, // internal fast rc, no pins
		OSS_OSC_PAIRED    = 2'h3  // internal fast rc plus slow crystal
	} oss_osc_t;
	// internal fast rc frequency option
	typedef enum logic [1:0] {
		OSS_FREQ_4M  = 2'h0,
		OSS_FREQ_8M  = 2'h1,
		OSS_FREQ_12M = 2'h2
	} oss_freq_t;
	// clock switch states, gray along fast-slow-fast
	typedef enum logic [1:0] {
		OSS_SW_FAST    = 2'h0,
		OSS_SW_TO_SLOW = 2'h1,
		OSS_SW_SLOW    = 2'h3,
		OSS_SW_TO_FAST = 2'h2
	} oss_sw_state_t;
endpackage

// *** oss_sw_if.sv ***
/*
 * interface between the top and the glitch-free clock switch.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface oss_sw_if;
	logic fast_tick;   // tick of the fast source
	logic slow_tick;   // tick of the slow crystal
	logic want_slow;   // request for slow system clock
	logic tick;        // selected system clock tick
	logic fast_en;     // fast rc must run
	logic slow_active; // slow crystal drives system clock
	logic busy;        // hand-over in progress
	modport ctrl (output fast_tick, slow_tick, want_slow,
	              input tick, fast_en, slow_active, busy);
	modport sw   (input fast_tick, slow_tick, want_slow,
	              output tick, fast_en, slow_active, busy);
endinterface

// *** oss_sync3.sv ***
/*
 * three-stage synchroniser with rising edge tick for an oscillator level.
 * assumes raw comes from outside the clk domain.
 */
`timescale 1ns/1ps
module oss_sync3 (
	// clock and control
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// oscillator level and tick
	input  wire logic raw,
	output logic      rise
);
	logic ff1;   // first stage, read by ff2 only
	logic ff2;   // second stage
	logic ff3;   // third stage
	logic level; // accepted level

	// shift and accept a level once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			ff1 <= 1'b0;
			ff2 <= 1'b0;
			ff3 <= 1'b0;
			level <= 1'b0;
		end else if (ce) begin
			ff1 <= raw;
			ff2 <= ff1;
			ff3 <= ff2;
			if (ff2 == ff3) begin
				level <= ff3;
			end
		end
	end

	// one tick per accepted rising change
	assign rise = ce && (ff2 == ff3) && ff3 && !level;
endmodule

// *** oss_clk_switch.sv ***
/*
 * glitch-free hand-over of the system clock tick between fast and slow.
 * assumes ticks are single-cycle enables on the same clock.
 */
`timescale 1ns/1ps
module oss_clk_switch (
	// clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// switch requests and ticks
	oss_sw_if.sw     sw
);
	oss_pkg::oss_sw_state_t state;      // current hand-over state
	oss_pkg::oss_sw_state_t next_state; // next hand-over state
	wire                    on_slow;    // slow source feeds the tick

	// new clock takes over only on its own tick, old one stops after
	always_comb begin
		next_state = state;
		case (state)
			oss_pkg::OSS_SW_FAST:    if (sw.want_slow) next_state = oss_pkg::OSS_SW_TO_SLOW;
			oss_pkg::OSS_SW_TO_SLOW: if (sw.slow_tick) next_state = oss_pkg::OSS_SW_SLOW;
			oss_pkg::OSS_SW_SLOW:    if (!sw.want_slow) next_state = oss_pkg::OSS_SW_TO_FAST;
			oss_pkg::OSS_SW_TO_FAST: if (sw.fast_tick) next_state = oss_pkg::OSS_SW_FAST;
			default:                 next_state = oss_pkg::OSS_SW_FAST;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= oss_pkg::OSS_SW_FAST;
		end else if (ce) begin
			state <= next_state;
		end
	end

	assign on_slow        = (state == oss_pkg::OSS_SW_SLOW) || (state == oss_pkg::OSS_SW_TO_FAST);
	assign sw.tick        = on_slow ? sw.slow_tick : sw.fast_tick;
	assign sw.fast_en     = (state != oss_pkg::OSS_SW_SLOW);
	assign sw.slow_active = on_slow;
	assign sw.busy        = (state == oss_pkg::OSS_SW_TO_SLOW) || (state == oss_pkg::OSS_SW_TO_FAST);

	// slow state entered only on a slow tick
	chk_slow_entry: assert property (@(posedge clk) disable iff (rst)
		(state == oss_pkg::OSS_SW_TO_SLOW) ##1 (state == oss_pkg::OSS_SW_SLOW) |-> $past(sw.slow_tick))
		else $error("slow clock taken without its tick");
	// fast rc only stops once the slow clock has taken over
	chk_fast_kept: assert property (@(posedge clk) disable iff (rst)
		$fell(sw.fast_en) |-> sw.slow_active)
		else $error("fast rc stopped before hand-over");
endmodule

// *** system_oscillator_select_test.sv ***
/*
 * self-checking bench for the oscillator select top: options, pins,
 * slow crystal power mode, clock hand-over, sleep and register bus.
 * assumes oss_consts.svh is on the include path and a 100 MHz clock.
 */
`timescale 1ns/1ps
module system_oscillator_select_test;
`include "oss_consts.svh"
	// clock, reset, options
	logic        clk, rst, ce, cfg_slow_rc_en, sleep_req;
	logic [1:0]  cfg_osc_type, cfg_fast_rc_freq;
	// oscillator levels from one free counter
	logic [7:0]  osc_cnt;
	wire logic   int_fast_rc_osc = osc_cnt[3];
	wire logic   osc_pin_in      = osc_cnt[6];
	wire logic   int_slow_rc_osc = osc_cnt[7];
	// outputs
	logic        osc_amp_en, fast_rc_en, slow_osc_en, slow_osc_low_power, slow_rc_en;
	logic        port_a_bit5_gpio, port_a_bit6_gpio, sys_tick, wdt_tick, timebase_tick;
	logic [1:0]  fast_rc_freq_sel, s_axi_bresp, s_axi_rresp;
	// bus
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          fails, comparisons;

	oss_top dut_u (.clk(clk), .rst(rst), .ce(ce), .cfg_osc_type(cfg_osc_type),
		.cfg_fast_rc_freq(cfg_fast_rc_freq), .cfg_slow_rc_en(cfg_slow_rc_en), .osc_pin_in(osc_pin_in),
		.int_fast_rc_osc(int_fast_rc_osc), .int_slow_rc_osc(int_slow_rc_osc), .sleep_req(sleep_req),
		.osc_amp_en(osc_amp_en), .fast_rc_en(fast_rc_en), .fast_rc_freq_sel(fast_rc_freq_sel),
		.slow_osc_en(slow_osc_en), .slow_osc_low_power(slow_osc_low_power), .slow_rc_en(slow_rc_en),
		.port_a_bit5_gpio(port_a_bit5_gpio), .port_a_bit6_gpio(port_a_bit6_gpio), .sys_tick(sys_tick),
		.wdt_tick(wdt_tick), .timebase_tick(timebase_tick), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	// clock and oscillator stand-ins, fast rc well below clk/8
	always #5 clk = ~clk;
	always @(posedge clk) osc_cnt <= osc_cnt + 8'h01;

	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// verdict and end of run
	task results;
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// options are only taken at reset, so each config needs one
	task automatic do_reset(input logic [1:0] ty, input logic [1:0] fr, input logic sr);
		@(posedge clk);
		cfg_osc_type <= ty;
		cfg_fast_rc_freq <= fr;
		cfg_slow_rc_en <= sr;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// axi4-lite write, address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (!ad && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				ad = 1;
			end
			if (!wd && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				wd = 1;
			end
		end while (!(ad && wd));
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// axi4-lite read
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// count tick pulses over n cycles
	task automatic ticks(input int n, output int s, output int t, output int w);
		s = 0;
		t = 0;
		w = 0;
		repeat (n) begin
			@(posedge clk);
			s += sys_tick;
			t += timebase_tick;
			w += wdt_tick;
		end
	endtask

	// poll until the slow-active status bit reaches v
	task automatic wait_slow(input logic v);
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		n = 0;
		do begin
			axr(`OSS_OFF_STATUS, d, r);
			n++;
		end while (d[`OSS_ST_SLOWACT] !== v && n < 100);
		chk("slow active", v, d[`OSS_ST_SLOWACT]);
		chk("busy", 0, d[`OSS_ST_BUSY]);
	endtask

	// every source config, pin release, latched options
	task automatic t_config;
		logic [3:0]  e5, e6, amp, frc, slo;
		logic [31:0] d;
		logic [1:0]  r, f;
		e5 = 4'b0110;
		e6 = 4'b0100;
		amp = 4'b1001;
		frc = 4'b1100;
		slo = 4'b1000;
		for (int t = 0; t < 4; t++) begin
			f = (t == 3) ? 2'h1 : t[1:0];
			do_reset(t[1:0], f, t[0]);
			cfg_osc_type <= ~t[1:0];
			repeat (3) @(posedge clk);
			chk("bit5 gpio", e5[t], port_a_bit5_gpio);
			chk("bit6 gpio", e6[t], port_a_bit6_gpio);
			chk("amp en", amp[t], osc_amp_en);
			chk("fast rc en", frc[t], fast_rc_en);
			chk("slow osc en", slo[t], slow_osc_en);
			chk("slow rc en", t[0], slow_rc_en);
			if (t[1]) chk("freq sel", f, fast_rc_freq_sel);
			axr(`OSS_OFF_STATUS, d, r);
			chk("status", {25'h0, t[0], f, t[1:0], 2'b00}, d);
		end
	endtask

	// ctrl reset value and slow crystal power mode, paired config
	task automatic t_lowpower;
		logic [31:0] d;
		logic [1:0]  r;
		int          s, t, w;
		axr(`OSS_OFF_CTRL, d, r);
		chk("ctrl reset", 0, d);
		axw(`OSS_OFF_CTRL, 32'h0000_0002, r);
		@(posedge clk);
		chk("low power", 1, slow_osc_low_power);
		chk("slow on lp", 1, slow_osc_en);
		ticks(300, s, t, w);
		chk("lp timebase", 1, t > 0);
		axw(`OSS_OFF_CTRL, 32'h0000_0000, r);
		@(posedge clk);
		chk("quick start", 0, slow_osc_low_power);
	endtask

	// hand-over to slow and back
	task automatic t_switch;
		logic [1:0] r;
		int         s, t, w;
		axw(`OSS_OFF_CTRL, 32'h0000_0001, r);
		wait_slow(1'b1);
		chk("rc stopped", 0, fast_rc_en);
		ticks(256, s, t, w);
		chk("slow sys rate", 1, s >= 1 && s <= 3);
		axw(`OSS_OFF_CTRL, 32'h0000_0000, r);
		wait_slow(1'b0);
		chk("rc back", 1, fast_rc_en);
		ticks(256, s, t, w);
		chk("fast sys rate", 1, s > 8);
	endtask

	// sleep stops the system tick, slow clocks keep running
	task automatic t_sleep;
		logic [31:0] d;
		logic [1:0]  r;
		int          s, t, w;
		sleep_req <= 1'b1;
		repeat (3) @(posedge clk);
		ticks(300, s, t, w);
		chk("sleep sys", 0, s);
		chk("sleep timebase", 1, t > 0);
		chk("sleep wdt", 1, w > 0);
		chk("sleep slow osc", 1, slow_osc_en);
		axr(`OSS_OFF_STATUS, d, r);
		chk("status sleep", 1, d[`OSS_ST_SLEEP]);
		sleep_req <= 1'b0;
	endtask

	// refused accesses and a control write with all byte enables off
	task automatic t_bus;
		logic [31:0] d;
		logic [1:0]  r;
		axw(`OSS_OFF_STATUS, 32'h0000_00ff, r);
		chk("ro write resp", `OSS_RESP_SLVERR, r);
		axw(8'h10, 32'h0000_0003, r);
		chk("unmapped wr resp", `OSS_RESP_SLVERR, r);
		axr(8'h10, d, r);
		chk("unmapped rd resp", `OSS_RESP_SLVERR, r);
		chk("unmapped rd data", `OSS_DATA_ZERO, d);
		s_axi_wstrb <= 4'h0;
		axw(`OSS_OFF_CTRL, 32'h0000_0003, r);
		s_axi_wstrb <= 4'hf;
		chk("masked wr resp", `OSS_RESP_OKAY, r);
		axr(`OSS_OFF_CTRL, d, r);
		chk("masked wr data", 0, d);
	endtask

	// clock enable low freezes the registered system tick
	task automatic t_freeze;
		logic v;
		int   n;
		n = 0;
		ce <= 1'b0;
		@(posedge clk);
		v = sys_tick;
		repeat (64) begin
			@(posedge clk);
			n += (sys_tick !== v);
		end
		ce <= 1'b1;
		chk("frozen sys tick", 0, n);
	endtask

	// slow select and low power have no effect in the internal fast rc config
	task automatic t_unpaired;
		logic [31:0] d;
		logic [1:0]  r;
		do_reset(2'h2, 2'h3, 1'b0);
		axw(`OSS_OFF_CTRL, 32'h0000_0003, r);
		repeat (300) @(posedge clk);
		chk("lp unpaired", 0, slow_osc_low_power);
		chk("rc stays", 1, fast_rc_en);
		chk("reserved freq", oss_pkg::OSS_FREQ_4M, fast_rc_freq_sel);
		axr(`OSS_OFF_STATUS, d, r);
		chk("no slow", 0, d[`OSS_ST_SLOWACT]);
	endtask

	// main sequence
	initial begin
		clk = 0;
		rst = 1;
		ce = 1;
		osc_cnt = 0;
		sleep_req = 0;
		cfg_osc_type = 0;
		cfg_fast_rc_freq = 0;
		cfg_slow_rc_en = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		fails = 0;
		comparisons = 0;
		t_config();
		t_lowpower();
		t_switch();
		t_freeze();
		t_sleep();
		t_bus();
		t_unpaired();
		results();
	end

	// watchdog against a hang
	initial begin
		#500_000;
		fails++;
		results();
	end
endmodule
